// File: pkg/pldec_pkg.sv
package pldec_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned NUM_PORTS    = 5;
  localparam int unsigned NUM_IND      = 4;
  localparam int unsigned STRAP_W      = 4;

  // ==========================================================
  // Strap decode
  localparam logic [1:0] MODE_0        = 2'h0;
  localparam logic [1:0] MODE_1        = 2'h1;
  localparam logic [1:0] MODE_2        = 2'h2;
  localparam logic [1:0] MODE_3        = 2'h3;
  localparam logic [1:0] STRAP_HI_NORM = 2'h0;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned STRETCH_MS   = 50;
  localparam int unsigned STRETCH_CYC  = CLK_HZ / 1000 * STRETCH_MS;
  localparam int unsigned BLINK_MS     = 40;
  localparam int unsigned BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned COL_BLINK_MS = 100;
  localparam int unsigned COL_BLINK_CYC = CLK_HZ / 1000 * COL_BLINK_MS;

  // ==========================================================
  // Pin levels
  localparam logic        IND_OFF      = 1'h1;

  // ==========================================================
  // Per-port status
  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic collision;
    logic tx_active;
    logic rx_active;
  } pldec_status_t;

endpackage

// File: verif/pldec_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Indicator checker
module pldec_chk #(
  parameter int unsigned NUM_PORTS   = 5,
  parameter int unsigned STRETCH_CYC = 4
) (
  // Clock and reset
  input wire logic                                     i_clk,
  input wire logic                                     i_sys_rst,
  // Straps and status
  input wire logic [3:0]                               i_indicator_mode_strap,
  input wire pldec_pkg::pldec_status_t [NUM_PORTS-1:0] i_port_status,
  // Pins
  input wire logic [NUM_PORTS-1:0]                     o_port_indicator_zero_n,
  input wire logic [NUM_PORTS-1:0]                     o_port_indicator_one_n,
  input wire logic [NUM_PORTS-1:0]                     o_port_indicator_two_n,
  input wire logic [NUM_PORTS-1:0]                     o_port_indicator_three_n,
  input wire logic                                     o_test_mode_strap
);
  logic [NUM_PORTS-1:0] lnk, spd, fdx, tx, rx, col;
  logic [1:0]           cnt_q;
  logic [1:0]           m;
  logic                 tf_q;
  logic                 ok;
  logic [31:0]          idle_q;
  assign ok = (cnt_q == 2'h3);
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      lnk[p] = i_port_status[p].link_up;
      spd[p] = i_port_status[p].speed_100;
      fdx[p] = i_port_status[p].full_duplex;
      tx[p]  = i_port_status[p].tx_active;
      rx[p]  = i_port_status[p].rx_active;
      col[p] = i_port_status[p].collision;
    end
  end
  // Mode and settle tracking
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 2'h0;
      m     <= i_indicator_mode_strap[1:0];
      tf_q  <= |i_indicator_mode_strap[3:2];
    end else if (!ok) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Idle run of port 0 transmit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || tx[0]) begin
      idle_q <= 32'h0;
    end else if (idle_q < STRETCH_CYC + 3) begin
      idle_q <= idle_q + 32'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_m1;
    ok && m == 2'h1;
  endsequence
  sequence s_tx_done;
    s_m1 ##0 idle_q > STRETCH_CYC + 1;
  endsequence
  AST_SPEED: assert property (ok |=> o_port_indicator_zero_n == ~$past(spd))
    else $error("speed indicator wrong");
  AST_DUPLEX: assert property (ok && m == 2'h0 |=> o_port_indicator_one_n == ~$past(fdx))
    else $error("duplex indicator wrong");
  AST_LINK: assert property (ok && m inside {2'h1, 2'h2} |=> o_port_indicator_one_n == ~$past(lnk))
    else $error("link indicator wrong");
  AST_RSVD: assert property (ok && m == 2'h3 |-> o_port_indicator_one_n == '1)
    else $error("reserved indicator lit");
  AST_TX: assert property (s_m1 |=> (o_port_indicator_two_n & $past(tx)) == '0)
    else $error("transmit indicator dark");
  AST_RX: assert property (s_m1 |=> (o_port_indicator_three_n & $past(rx)) == '0)
    else $error("receive indicator dark");
  AST_COL: assert property (ok && m == 2'h0 |=> (o_port_indicator_two_n & $past(col)) == '0)
    else $error("collision indicator dark");
  AST_ACT: assert property (ok && m == 2'h2 |=> (o_port_indicator_three_n & $past(tx | rx)) == '0)
    else $error("activity indicator dark");
  AST_FDX: assert property (ok && m[1] |=> (o_port_indicator_two_n & $past(fdx)) == '0)
    else $error("full duplex not steady");
  AST_NOLINK: assert property (ok && m != 2'h1 && m != 2'h2 |=> (~o_port_indicator_three_n & ~$past(lnk)) == '0)
    else $error("link activity lit without link");
  AST_STRETCH: assert property (s_tx_done |-> o_port_indicator_two_n[0])
    else $error("transmit stretch too long");
  AST_FLAG: assert property (ok |-> o_test_mode_strap == tf_q)
    else $error("test strap flag wrong");
endmodule
bind pldec_top pldec_chk #(.NUM_PORTS(NUM_PORTS), .STRETCH_CYC(STRETCH_CYC)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_indicator_mode_strap(i_indicator_mode_strap),
  .i_port_status(i_port_status), .o_port_indicator_zero_n(o_port_indicator_zero_n),
  .o_port_indicator_one_n(o_port_indicator_one_n), .o_port_indicator_two_n(o_port_indicator_two_n),
  .o_port_indicator_three_n(o_port_indicator_three_n), .o_test_mode_strap(o_test_mode_strap));
`default_nettype wire

// File: verif/pldec_led_board.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Board with indicator lamps
module pldec_led_board #(
  parameter int unsigned NUM_PORTS = 5
) (
  // Indicator pins
  input  wire logic [NUM_PORTS-1:0]   i_ind0_n,
  input  wire logic [NUM_PORTS-1:0]   i_ind1_n,
  input  wire logic [NUM_PORTS-1:0]   i_ind2_n,
  input  wire logic [NUM_PORTS-1:0]   i_ind3_n,
  // Board view
  output logic      [4*NUM_PORTS-1:0] o_lit,
  output logic      [NUM_PORTS-1:0]   o_fiber_signal_detect
);
  assign o_lit = ~{i_ind3_n, i_ind2_n, i_ind1_n, i_ind0_n};
  assign o_fiber_signal_detect = '0;
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench
module tb_top;
  localparam int unsigned NP = pldec_pkg::NUM_PORTS;
  localparam int unsigned SC = 4;
  typedef struct packed {
    logic [3:0] strap;
    logic [5:0] st;
    logic [3:0] lit;
    logic       flag;
  } pldec_row_t;
  localparam pldec_row_t ROWS [10] = '{
    '{4'h0, 6'h30, 4'h9, 1'h0}, '{4'h0, 6'h0c, 4'h6, 1'h0}, '{4'h1, 6'h22, 4'h6, 1'h0},
    '{4'h1, 6'h11, 4'h9, 1'h0}, '{4'h2, 6'h28, 4'h6, 1'h0}, '{4'h2, 6'h11, 4'h9, 1'h0},
    '{4'h3, 6'h38, 4'hd, 1'h0}, '{4'h3, 6'h00, 4'h0, 1'h0}, '{4'h5, 6'h22, 4'h6, 1'h1},
    '{4'hc, 6'h04, 4'h4, 1'h1}};
  logic                                clk = 1'h0;
  logic                                rst = 1'h1;
  logic [3:0]                          strap = 4'h0;
  pldec_pkg::pldec_status_t [NP-1:0]   st = '0;
  logic [NP-1:0]                       z_n, o_n, t_n, h_n, fsd;
  logic [4*NP-1:0]                     lit;
  logic                                test;
  int                                  error_cnt = 0;
  int                                  compares = 0;
  int                                  c2, c3;
  always #20 clk = ~clk;
  pldec_top #(.STRETCH_CYC(SC), .BLINK_CYC(4), .COL_BLINK_CYC(6)) uut (
    .i_clk(clk), .i_sys_rst(rst), .i_indicator_mode_strap(strap), .i_fiber_signal_detect(fsd),
    .i_port_status(st), .o_port_indicator_zero_n(z_n), .o_port_indicator_one_n(o_n),
    .o_port_indicator_two_n(t_n), .o_port_indicator_three_n(h_n), .o_test_mode_strap(test));
  pldec_led_board #(.NUM_PORTS(NP)) u_board (
    .i_ind0_n(z_n), .i_ind1_n(o_n), .i_ind2_n(t_n), .i_ind3_n(h_n), .o_lit(lit), .o_fiber_signal_detect(fsd));
  task cmp(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task boot(input logic [3:0] s, input logic [5:0] v);
    @(posedge clk);
    rst <= 1'h1;
    strap <= s;
    st <= {NP{v}};
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    repeat (SC + 8) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] expand(input logic [3:0] e);
    return 32'({{NP{e[3]}}, {NP{e[2]}}, {NP{e[1]}}, {NP{e[0]}}});
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    #1;
    cmp(32'h0, 32'(lit));
    cmp(32'h0, 32'(test));
    foreach (ROWS[i]) begin
      boot(ROWS[i].strap, ROWS[i].st);
      cmp(expand(ROWS[i].lit), 32'(lit));
      cmp(32'(ROWS[i].flag), 32'(test));
    end
    // One-cycle transmit on port 0
    boot(4'h1, 6'h20);
    @(posedge clk);
    st[0].tx_active <= 1'h1;
    @(posedge clk);
    st[0].tx_active <= 1'h0;
    @(posedge clk);
    #1;
    cmp(32'h1e, 32'(t_n));
    repeat (SC - 2) @(posedge clk);
    #1;
    cmp(32'h1e, 32'(t_n));
    repeat (4) @(posedge clk);
    #1;
    cmp(32'h1f, 32'(t_n));
    // Late strap change
    @(posedge clk);
    strap <= 4'h0;
    st <= {NP{6'h08}};
    repeat (8) @(posedge clk);
    #1;
    cmp(32'h1f, 32'(o_n));
    // Blinking in mode 3
    boot(4'h3, 6'h25);
    c2 = 0;
    c3 = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      c2 += int'(t_n[0]);
      c3 += int'(h_n[0]);
    end
    cmp(32'h1, 32'(c2 > 0 && c2 < 40));
    cmp(32'h1, 32'(c3 > 0 && c3 < 40));
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: verilog/pldec_stretch.sv
`timescale 1ns/1ps
`default_nettype none

module pldec_stretch #(
  parameter int unsigned HOLD_CYC = 1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Event
  input  wire logic i_event,
  output logic      o_stretched
);

  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  // Elaboration-time parameter check
  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("HOLD_CYC must be at least 1");
  end

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Hold event for minimum on-time
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (i_event) begin
      cnt_q <= CW'(HOLD_CYC);   // [RULE_14]
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  assign o_stretched = i_event || (cnt_q != '0);

endmodule

`default_nettype wire

// File: verilog/pldec_top.sv
// Function
// RULE_01: Indicator 0 shows speed, on at 100.
// RULE_02: Mode 0: indicator 1 shows full duplex.
// RULE_03: Modes 1,2: indicator 1 shows link; 3 reserved.
// RULE_04: Mode 0: indicator 2 shows collision.
// RULE_05: Mode 1: indicator 2 shows transmit.
// RULE_06: Modes 2,3: full steady, collision blinks.
// RULE_07: Modes 0,3: indicator 3 link plus activity.
// RULE_08: Mode 1: indicator 3 shows receive.
// RULE_09: Mode 2: indicator 3 shows any activity.
// RULE_10: Straps pick mode; pins active low.
// RULE_11: Board ties fiber detect low for copper.
// RULE_12: Upper strap bits low; others test.
// RULE_13: Link lit, blinks off on activity.
// RULE_14: Stretch events; sample straps after reset.
`timescale 1ns/1ps
`default_nettype none

module pldec_top #(
  parameter int unsigned NUM_PORTS     = pldec_pkg::NUM_PORTS,
  parameter int unsigned STRETCH_CYC   = pldec_pkg::STRETCH_CYC,
  parameter int unsigned BLINK_CYC     = pldec_pkg::BLINK_CYC,
  parameter int unsigned COL_BLINK_CYC = pldec_pkg::COL_BLINK_CYC
) (
  // Clock and reset
  input  wire logic                                 i_clk,
  input  wire logic                                 i_sys_rst,
  // Straps and board pins
  input  wire logic [pldec_pkg::STRAP_W-1:0]        i_indicator_mode_strap,
  input  wire logic [NUM_PORTS-1:0]                 i_fiber_signal_detect,
  // Port status from PHY and MAC
  input  wire pldec_pkg::pldec_status_t [NUM_PORTS-1:0] i_port_status,
  // Indicator pins, active low
  output logic [NUM_PORTS-1:0]                      o_port_indicator_zero_n,
  output logic [NUM_PORTS-1:0]                      o_port_indicator_one_n,
  output logic [NUM_PORTS-1:0]                      o_port_indicator_two_n,
  output logic [NUM_PORTS-1:0]                      o_port_indicator_three_n,
  // Strap status
  output logic                                      o_test_mode_strap
);

  // Elaboration-time parameter check
  if (NUM_PORTS < 1 || STRETCH_CYC < 1 || BLINK_CYC < 2 || COL_BLINK_CYC < 2) begin : g_bad_param
    $error("pldec_top: illegal parameter value");
  end

  // Wide enough for the full two-phase period of either timebase
  localparam int unsigned BW = $clog2(2 * (COL_BLINK_CYC + BLINK_CYC));

  // ==========================================================
  // Mode decode
  typedef enum logic [3:0] {
    PLDEC_M0 = 4'h1,
    PLDEC_M1 = 4'h2,
    PLDEC_M2 = 4'h4,
    PLDEC_M3 = 4'h8
  } pldec_mode_t;

  logic [pldec_pkg::STRAP_W-1:0] strap_s1_q;
  logic [pldec_pkg::STRAP_W-1:0] strap_s2_q;
  logic                          rst_d1_q;
  pldec_mode_t                   mode_q;
  logic                          test_q;

  // Strap synchroniser
  always_ff @(posedge i_clk) begin
    strap_s1_q <= i_indicator_mode_strap;
    strap_s2_q <= strap_s1_q;
  end

  always_ff @(posedge i_clk) begin
    rst_d1_q <= i_sys_rst;
  end

  // Latch mode once at reset release
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_q <= PLDEC_M0;
      test_q <= 1'b0;
    end else if (rst_d1_q) begin
      test_q <= (strap_s2_q[3:2] != pldec_pkg::STRAP_HI_NORM);   // [RULE_12]
      unique case (strap_s2_q[1:0])   // [RULE_10] [RULE_14]
        pldec_pkg::MODE_0: mode_q <= PLDEC_M0;
        pldec_pkg::MODE_1: mode_q <= PLDEC_M1;
        pldec_pkg::MODE_2: mode_q <= PLDEC_M2;
        pldec_pkg::MODE_3: mode_q <= PLDEC_M3;
      endcase
    end
  end

  // ==========================================================
  // Shared blink timebases for activity and collision
  logic [BW-1:0] blink_cnt_q;
  logic [BW-1:0] col_cnt_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || blink_cnt_q == BW'(2 * BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
    end else begin
      blink_cnt_q <= blink_cnt_q + BW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || col_cnt_q == BW'(2 * COL_BLINK_CYC - 1)) begin
      col_cnt_q <= '0;
    end else begin
      col_cnt_q <= col_cnt_q + BW'(1);
    end
  end

  logic act_phase_off;
  logic col_phase_on;
  assign act_phase_off = (blink_cnt_q >= BW'(BLINK_CYC));
  assign col_phase_on  = (col_cnt_q < BW'(COL_BLINK_CYC));

  // ==========================================================
  // Per-port status sync and stretch
  logic [NUM_PORTS-1:0] fsd_s1_q;
  logic [NUM_PORTS-1:0] fsd_s2_q;
  logic [NUM_PORTS-1:0] col_str;
  logic [NUM_PORTS-1:0] tx_str;
  logic [NUM_PORTS-1:0] rx_str;
  logic [NUM_PORTS-1:0] ind0_d;
  logic [NUM_PORTS-1:0] ind1_d;
  logic [NUM_PORTS-1:0] ind2_d;
  logic [NUM_PORTS-1:0] ind3_d;

  // Fiber detect is board level, only synchronised
  always_ff @(posedge i_clk) begin
    fsd_s1_q <= i_fiber_signal_detect;   // [RULE_11]
    fsd_s2_q <= fsd_s1_q;
  end

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pldec_stretch #(.HOLD_CYC(STRETCH_CYC)) u_col (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_event     (i_port_status[p].collision),
      .o_stretched (col_str[p])
    );
    pldec_stretch #(.HOLD_CYC(STRETCH_CYC)) u_tx (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_event     (i_port_status[p].tx_active),
      .o_stretched (tx_str[p])
    );
    pldec_stretch #(.HOLD_CYC(STRETCH_CYC)) u_rx (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_event     (i_port_status[p].rx_active),
      .o_stretched (rx_str[p])
    );
  end

  // ==========================================================
  // Indicator mapping, active high here
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      logic link;
      logic act;
      logic fd;
      link = i_port_status[p].link_up;
      act  = tx_str[p] || rx_str[p];
      fd   = i_port_status[p].full_duplex;
      ind0_d[p] = i_port_status[p].speed_100;   // [RULE_01]
      ind1_d[p] = 1'b0;
      ind2_d[p] = 1'b0;
      ind3_d[p] = 1'b0;
      unique case (mode_q)
        PLDEC_M0: begin
          ind1_d[p] = fd;   // [RULE_02]
          ind2_d[p] = col_str[p];   // [RULE_04]
          ind3_d[p] = link && !(act && act_phase_off);   // [RULE_07] [RULE_13]
        end
        PLDEC_M1: begin
          ind1_d[p] = link;   // [RULE_03]
          ind2_d[p] = tx_str[p];   // [RULE_05]
          ind3_d[p] = rx_str[p];   // [RULE_08]
        end
        PLDEC_M2: begin
          ind1_d[p] = link;   // [RULE_03]
          ind2_d[p] = fd || (col_str[p] && col_phase_on);   // [RULE_06]
          ind3_d[p] = act;   // [RULE_09]
        end
        PLDEC_M3: begin
          ind1_d[p] = 1'b0;   // [RULE_03]
          ind2_d[p] = fd || (col_str[p] && col_phase_on);   // [RULE_06]
          ind3_d[p] = link && !(act && act_phase_off);   // [RULE_07] [RULE_13]
        end
      endcase
    end
  end

  // ==========================================================
  // Registered active-low pins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_indicator_zero_n  <= {NUM_PORTS{pldec_pkg::IND_OFF}};
      o_port_indicator_one_n   <= {NUM_PORTS{pldec_pkg::IND_OFF}};
      o_port_indicator_two_n   <= {NUM_PORTS{pldec_pkg::IND_OFF}};
      o_port_indicator_three_n <= {NUM_PORTS{pldec_pkg::IND_OFF}};
    end else begin
      o_port_indicator_zero_n  <= ~ind0_d;   // [RULE_10]
      o_port_indicator_one_n   <= ~ind1_d;
      o_port_indicator_two_n   <= ~ind2_d;
      o_port_indicator_three_n <= ~ind3_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_test_mode_strap <= 1'b0;
    end else begin
      o_test_mode_strap <= test_q;
    end
  end

endmodule

`default_nettype wire
